// *** logic/mepsag_pkg.sv ***
// Shared constants for the metering engine control, pulse and sag logic
package mepsag_pkg;

	// ****************************************
	// Engine word addresses
	// ****************************************
	localparam logic [7:0] CE_ENV = 8'h10;
	localparam logic [7:0] CE_CFG = 8'h20;
	localparam logic [7:0] CE_RATE = 8'h21;
	localparam logic [7:0] CE_SAGTHR = 8'h24;
	localparam logic [7:0] CE_GAIN0 = 8'h40;
	localparam logic [7:0] CE_GAIN1 = 8'h41;
	localparam logic [7:0] CE_GAIN2 = 8'h42;
	localparam logic [7:0] CE_PULSEW = 8'h45;
	localparam logic [7:0] CE_PULSER = 8'h46;
	localparam logic [7:0] CE_STATUS = 8'h80;
	localparam logic [7:0] CE_W0SUM = 8'h84;
	localparam logic [7:0] CE_VAR0SUM = 8'h85;
	localparam logic [7:0] CE_ADC_LAST = 8'h0A;
	localparam int ADC_IA = 0;
	localparam int ADC_IA2 = 1;
	localparam int ADC_IB = 2;
	localparam int ADC_IB2 = 3;
	localparam int ADC_VB = 9;
	localparam int ADC_VA = 10;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int CFG_SLOW = 0;
	localparam int CFG_FAST = 1;
	localparam int CFG_EXTP = 5;
	localparam int CFG_SAGCNT = 8;
	localparam int SAGCNT_W = 12;
	localparam int CFG_SAGINT = 20;
	localparam logic [31:0] CFG_RESET = 32'h0030_FC20;
	localparam logic [31:0] RATE_RESET = 32'h0000_0000;
	localparam logic [31:0] GAIN_UNITY = 32'h0000_4000;
	localparam int GAIN_FRAC = 14;
	localparam int ENV_RUN = 0;
	localparam int ENV_EQU = 5;
	localparam int ENV_DIFFA = 8;
	localparam int ENV_DIFFB = 9;
	localparam int ENV_RMT = 10;
	localparam int ENV_SUM = 16;
	localparam int SUM_W = 13;
	localparam int ST_SAGA = 0;
	localparam int ST_SAGB = 1;
	localparam int ST_F0 = 3;
	localparam int ACC_SHIFT = 13;

	// ****************************************
	// Timing
	// ****************************************
	localparam longint CLK_HZ = 10_000_000;
	localparam longint FS_MILLIHZ = 2_520_620;
	localparam int SAMPLE_CYC = int'((CLK_HZ * 1000) / FS_MILLIHZ);
	localparam int SLOTS = 3;
	localparam int SLOT_CYC = SAMPLE_CYC / SLOTS;
	localparam int PULSE_HI_CYC = SLOT_CYC / 2;
	localparam int PULSE_FRAC = 46;

	// ****************************************
	// Host APB map
	// ****************************************
	localparam logic [7:0] APB_CMD = 8'h00;
	localparam logic [7:0] APB_WDATA = 8'h04;
	localparam logic [7:0] APB_RDATA = 8'h08;
	localparam logic [7:0] APB_STATUS = 8'h0C;
	localparam logic [7:0] APB_W0SUM = 8'h10;
	localparam logic [7:0] APB_VAR0SUM = 8'h14;
	localparam int CMD_WR = 8;
	localparam int CMD_GO = 31;

endpackage : mepsag_pkg

// *** logic/mepsag_if.sv ***
// Engine word bus between the processor end and the metering engine
`timescale 1ns/100ps
interface mepsag_if;
	logic req;
	logic wr;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic ack;
	logic xfer;
	logic sag_warn;

	modport engine (input req, wr, addr, wdata, output rdata, ack, xfer, sag_warn);
	modport processor (output req, wr, addr, wdata, input rdata, ack, xfer, sag_warn);
endinterface : mepsag_if

// *** logic/mepsag_pulse.sv ***
// Rate-scaled energy pulse generator with saturation and slot timing
`timescale 1ns/100ps
module mepsag_pulse
	import mepsag_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Timing enables
	input wire logic i_sample,
	input wire logic i_slot,
	// Pulse input and scaling
	input wire logic [31:0] i_energy,
	input wire logic [31:0] i_rate,
	input wire logic i_fast,
	input wire logic i_slow,
	// Pulse out
	output logic o_pulse
);

	typedef struct packed {
		logic [PULSE_FRAC-1:0] frac;
		logic [1:0] pend;
		logic [11:0] hi;
		logic pulse;
	} mepsag_pg_s;

	mepsag_pg_s s;
	mepsag_pg_s next_s;
	logic [31:0] mag;
	logic [71:0] scaled;
	logic [71:0] sum;
	logic [71:0] whole;

	always_comb begin
		next_s = s;
		mag = i_energy[31] ? 32'(-i_energy) : i_energy;
		// X is 1.5 * 2^k: 3 * product, then shift
		scaled = 72'(mag) * 72'(i_rate) * 72'(3);
		if (i_fast) begin
			scaled = scaled << 5;
		end else if (i_slow) begin
			scaled = scaled >> 5;
		end else begin
			scaled = scaled << 1;
		end
		sum = 72'(s.frac) + scaled;
		whole = (sum >> PULSE_FRAC) + 72'(s.pend);
		if (i_sample) begin
			next_s.frac = sum[PULSE_FRAC-1:0];
			// Clamp instead of wrap: three pulses per sample at most
			next_s.pend = (whole > 72'(SLOTS)) ? 2'(SLOTS) : whole[1:0];
		end
		if (s.hi != 12'h000) begin
			next_s.hi = s.hi - 12'h001;
		end else begin
			next_s.pulse = 1'b0;
		end
		// Edges only on slot ticks: error bounded, never accumulates
		if (i_slot && next_s.pend != 2'h0) begin
			next_s.pend = next_s.pend - 2'h1;
			next_s.pulse = 1'b1;
			next_s.hi = 12'(PULSE_HI_CYC - 1);
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_pulse = s.pulse;

endmodule : mepsag_pulse

// *** logic/mepsag_engine.sv ***
// Metering engine end: config, accumulation, pulses, sag and status words
`timescale 1ns/100ps
module mepsag_engine
	import mepsag_pkg::*;
(
	// Clock and reset
	input wire logic I_MCLK,
	input wire logic I_RESETN,
	// Converter samples, same clock domain
	input wire logic I_ADC_VALID,
	input wire logic [3:0] I_ADC_INDEX,
	input wire logic [31:0] I_ADC_DATA,
	// Processor side
	mepsag_if.engine bus,
	// Pulse outputs
	output logic O_REAL_PULSE,
	output logic O_REACTIVE_PULSE
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [31:0] env;
		logic [31:0] cfg;
		logic [31:0] rate;
		logic [31:0] sag_threshold;
		logic [2:0][31:0] gain;
		logic [31:0] pw;
		logic [31:0] pr;
		logic [31:0] w0;
		logic [31:0] v0;
		logic [31:0] acc_w;
		logic [31:0] acc_v;
		logic [10:0][31:0] adc;
		logic [15:0] va_prev;
		logic [11:0] div;
		logic [SUM_W-1:0] nsamp;
		logic [1:0][SAGCNT_W-1:0] sag_run;
		logic [1:0] sag;
		logic f0;
		logic [31:0] rdata;
		logic ack;
		logic xfer;
		logic warn;
	} mepsag_eng_s;

	mepsag_eng_s s;
	mepsag_eng_s next_s;
	logic run;
	logic sample;
	logic slot;
	logic [15:0] va;
	logic [15:0] vb;
	logic [15:0] ia;
	logic [15:0] ib;
	logic [16:0] diff;
	logic signed [32:0] pw_term;
	logic signed [31:0] pv_term;
	logic [31:0] w_add;
	logic [31:0] v_add;
	logic [31:0] mag;
	logic [31:0] status;
	logic [SAGCNT_W-1:0] sag_sample_count;
	logic [SUM_W-1:0] sum_n;
	logic [1:0] pulses;

	// Gain in Q14 applied to the upper half of a sample
	function automatic logic [15:0] trim(input logic [31:0] x, input logic [31:0] g);
		logic signed [31:0] t;
		t = $signed(x[31:16]) * $signed(g[15:0]);
		return t[GAIN_FRAC+15:GAIN_FRAC];
	endfunction : trim

	always_comb begin
		next_s = s;
		next_s.ack = 1'b0;
		next_s.xfer = 1'b0;
		mag = 32'h0000_0000;
		run = s.env[ENV_RUN];
		sag_sample_count = s.cfg[CFG_SAGCNT +: SAGCNT_W];
		sum_n = s.env[ENV_SUM +: SUM_W];
		// ****************************************
		// Sample and slot enables
		// ****************************************
		next_s.div = (s.div == 12'(SAMPLE_CYC - 1)) ? 12'h000 : s.div + 12'h001;
		sample = run && s.div == 12'h000;
		slot = run && (s.div == 12'h000 || s.div == 12'(SLOT_CYC) || s.div == 12'(2 * SLOT_CYC));
		status = 32'h0000_0000;
		status[ST_SAGA] = s.sag[0];
		status[ST_SAGB] = s.sag[1];
		status[ST_F0] = s.f0;
		// ****************************************
		// Converter slots
		// ****************************************
		if (I_ADC_VALID) begin
			case (I_ADC_INDEX)
				4'h0: next_s.adc[ADC_IA] = I_ADC_DATA;
				4'h1: next_s.adc[s.env[ENV_DIFFA] ? ADC_IA : ADC_IA2] = I_ADC_DATA;
				4'h2: next_s.adc[ADC_IB] = I_ADC_DATA;
				4'h3: begin
					if (s.env[ENV_DIFFB] || s.env[ENV_RMT]) begin
						next_s.adc[ADC_IB] = I_ADC_DATA;
					end else begin
						next_s.adc[ADC_IB2] = I_ADC_DATA;
					end
				end
				4'h9: next_s.adc[ADC_VB] = I_ADC_DATA;
				4'hA: next_s.adc[ADC_VA] = I_ADC_DATA;
				default: next_s.adc[ADC_IA] = s.adc[ADC_IA];
			endcase
		end
		// ****************************************
		// Energy per sample
		// ****************************************
		va = trim(s.adc[ADC_VA], s.gain[0]);
		vb = trim(s.adc[ADC_VB], s.gain[0]);
		ia = trim(s.adc[ADC_IA], s.gain[1]);
		ib = trim(s.adc[ADC_IB], s.gain[2]);
		diff = {ia[15], ia} - {ib[15], ib};
		case (s.env[ENV_EQU +: 3])
			3'h1: pw_term = 33'($signed(va) * $signed(diff[16:1]));
			3'h2: pw_term = 33'($signed(va) * $signed(ia)) + 33'($signed(vb) * $signed(ib));
			default: pw_term = 33'($signed(va) * $signed(ia));
		endcase
		// Quadrature taken as the voltage one sample back; cheap, not exact
		pv_term = $signed(s.va_prev) * $signed(ia);
		w_add = 32'(pw_term >>> ACC_SHIFT);
		v_add = 32'(pv_term >>> ACC_SHIFT);
		if (sample) begin
			next_s.va_prev = va;
			next_s.f0 = ~va[15];
			if (s.nsamp + 13'h0001 >= sum_n) begin
				next_s.w0 = s.acc_w + w_add;
				next_s.v0 = s.acc_v + v_add;
				next_s.acc_w = 32'h0000_0000;
				next_s.acc_v = 32'h0000_0000;
				next_s.nsamp = '0;
				next_s.xfer = 1'b1;
				if (!s.cfg[CFG_EXTP]) begin
					next_s.pw = next_s.w0;
					next_s.pr = next_s.v0;
				end
			end else begin
				next_s.acc_w = s.acc_w + w_add;
				next_s.acc_v = s.acc_v + v_add;
				next_s.nsamp = s.nsamp + 13'h0001;
			end
			// ****************************************
			// Sag detection, one per voltage
			// ****************************************
			for (int k = 0; k < 2; k++) begin
				mag = s.adc[k == 0 ? ADC_VA : ADC_VB];
				mag = mag[31] ? 32'(-mag) : mag;
				if (mag < s.sag_threshold) begin
					if (s.sag_run[k] < sag_sample_count) begin
						next_s.sag_run[k] = s.sag_run[k] + 12'h001;
					end
					if (s.sag_run[k] + 12'h001 >= sag_sample_count) begin
						next_s.sag[k] = 1'b1;
					end
				end else if (mag > s.sag_threshold) begin
					next_s.sag_run[k] = '0;
					next_s.sag[k] = 1'b0;
				end
			end
		end
		next_s.warn = s.cfg[CFG_SAGINT] && (s.sag != 2'b00);
		// ****************************************
		// Word bus, one-cycle answer
		// ****************************************
		if (bus.req && !s.ack) begin
			next_s.ack = 1'b1;
			next_s.rdata = 32'h0000_0000;
			if (bus.wr) begin
				case (bus.addr)
					CE_ENV: next_s.env = bus.wdata;
					CE_CFG: next_s.cfg = bus.wdata;
					CE_RATE: next_s.rate = bus.wdata;
					CE_SAGTHR: next_s.sag_threshold = bus.wdata;
					CE_GAIN0: next_s.gain[0] = bus.wdata;
					CE_GAIN1: next_s.gain[1] = bus.wdata;
					CE_GAIN2: next_s.gain[2] = bus.wdata;
					CE_PULSEW: next_s.pw = s.cfg[CFG_EXTP] ? bus.wdata : next_s.pw;
					CE_PULSER: next_s.pr = s.cfg[CFG_EXTP] ? bus.wdata : next_s.pr;
					default: begin
						if (bus.addr <= CE_ADC_LAST) begin
							next_s.adc[bus.addr[3:0]] = bus.wdata;
						end
					end
				endcase
			end else begin
				case (bus.addr)
					CE_ENV: next_s.rdata = s.env;
					CE_CFG: next_s.rdata = s.cfg;
					CE_RATE: next_s.rdata = s.rate;
					CE_SAGTHR: next_s.rdata = s.sag_threshold;
					CE_GAIN0: next_s.rdata = s.gain[0];
					CE_GAIN1: next_s.rdata = s.gain[1];
					CE_GAIN2: next_s.rdata = s.gain[2];
					CE_PULSEW: next_s.rdata = s.pw;
					CE_PULSER: next_s.rdata = s.pr;
					CE_STATUS: next_s.rdata = status;
					CE_W0SUM: next_s.rdata = s.w0;
					CE_VAR0SUM: next_s.rdata = s.v0;
					default: begin
						if (bus.addr <= CE_ADC_LAST) begin
							next_s.rdata = s.adc[bus.addr[3:0]];
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			s <= '0;
			s.cfg <= CFG_RESET;
			s.rate <= RATE_RESET;
			s.gain <= {GAIN_UNITY, GAIN_UNITY, GAIN_UNITY};
		end else begin
			s <= next_s;
		end
	end

	// ****************************************
	// Pulse generators
	// ****************************************
	for (genvar g = 0; g < 2; g++) begin : gen_pulse
		mepsag_pulse u_pulse (
			.i_clk(I_MCLK),
			.i_resetn(I_RESETN),
			.i_sample(sample),
			.i_slot(slot),
			.i_energy(g == 0 ? s.pw : s.pr),
			.i_rate(s.rate),
			.i_fast(s.cfg[CFG_FAST]),
			.i_slow(s.cfg[CFG_SLOW]),
			.o_pulse(pulses[g])
		);
	end

	assign O_REAL_PULSE = pulses[0];
	assign O_REACTIVE_PULSE = pulses[1];
	assign bus.rdata = s.rdata;
	assign bus.ack = s.ack;
	assign bus.xfer = s.xfer;
	assign bus.sag_warn = s.warn;

endmodule : mepsag_engine

// *** logic/mepsag_host.sv ***
// Processor end: APB command registers and automatic result fetch
`timescale 1ns/100ps
module mepsag_host
	import mepsag_pkg::*;
(
	// Clock and reset
	input wire logic I_MCLK,
	input wire logic I_RESETN,
	// APB slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// Engine side
	mepsag_if.processor bus
);

	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_CMD = 4'b0010,
		H_FW = 4'b0100,
		H_FV = 4'b1000
	} mepsag_hst_e;

	typedef struct packed {
		mepsag_hst_e st;
		logic req;
		logic wr;
		logic [7:0] addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic [31:0] w0;
		logic [31:0] v0;
		logic xfer_flag;
		logic pend;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} mepsag_hst_s;

	mepsag_hst_s s;
	mepsag_hst_s next_s;
	logic access;
	logic clr;

	always_comb begin
		next_s = s;
		clr = 1'b0;
		access = I_PSEL && I_PENABLE && !s.pready;
		next_s.pready = access;
		next_s.pslverr = 1'b0;
		// ****************************************
		// APB decode
		// ****************************************
		if (access) begin
			next_s.prdata = 32'h0000_0000;
			case (I_PADDR)
				APB_CMD: begin
					if (I_PWRITE && I_PWDATA[CMD_GO]) begin
						// Busy engine link: refuse rather than queue
						if (s.st != H_IDLE || s.pend) begin
							next_s.pslverr = 1'b1;
						end else begin
							// Setup order before run enable is firmware's job
							next_s.addr = I_PWDATA[7:0];
							next_s.wr = I_PWDATA[CMD_WR];
							next_s.req = 1'b1;
							next_s.st = H_CMD;
						end
					end
				end
				APB_WDATA: begin
					if (I_PWRITE) begin
						next_s.wdata = I_PWDATA;
					end else begin
						next_s.prdata = s.wdata;
					end
				end
				APB_RDATA: next_s.prdata = s.rdata;
				APB_STATUS: begin
					clr = I_PWRITE && I_PWDATA[1];
					next_s.prdata = {29'h0, bus.sag_warn, s.xfer_flag, s.st != H_IDLE};
				end
				APB_W0SUM: next_s.prdata = s.w0;
				APB_VAR0SUM: next_s.prdata = s.v0;
				default: next_s.pslverr = 1'b1;
			endcase
		end
		// Set wins over a same-cycle clear
		next_s.xfer_flag = (s.xfer_flag && !clr) || bus.xfer;
		if (bus.xfer) begin
			next_s.pend = 1'b1;
		end
		// ****************************************
		// Engine word sequencer
		// ****************************************
		case (s.st)
			H_IDLE: begin
				if (s.pend) begin
					next_s.pend = bus.xfer;
					next_s.req = 1'b1;
					next_s.wr = 1'b0;
					next_s.addr = CE_W0SUM;
					next_s.st = H_FW;
				end
			end
			H_CMD: begin
				if (bus.ack) begin
					next_s.req = 1'b0;
					next_s.rdata = bus.rdata;
					next_s.st = H_IDLE;
				end
			end
			H_FW: begin
				if (bus.ack) begin
					next_s.w0 = bus.rdata;
					next_s.addr = CE_VAR0SUM;
					next_s.st = H_FV;
				end
			end
			H_FV: begin
				if (bus.ack) begin
					next_s.v0 = bus.rdata;
					next_s.req = 1'b0;
					next_s.st = H_IDLE;
				end
			end
			default: begin
				next_s.req = 1'b0;
				next_s.st = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_MCLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			s <= '0;
			s.st <= H_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign O_PRDATA = s.prdata;
	assign O_PREADY = s.pready;
	assign O_PSLVERR = s.pslverr;
	assign bus.req = s.req;
	assign bus.wr = s.wr;
	assign bus.addr = s.addr;
	assign bus.wdata = s.wdata;

endmodule : mepsag_host

// *** tb/mepsag_checker.sv ***
// Checker for the word link between the processor end and the engine end
`timescale 1ns/100ps
module mepsag_checker
	import mepsag_pkg::*;
(
	// Clock and reset
	input wire logic I_MCLK,
	input wire logic I_RESETN,
	// Word link
	input wire logic req,
	input wire logic wr,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic [31:0] rdata,
	input wire logic ack,
	input wire logic xfer,
	input wire logic sag_warn
);
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (!I_RESETN);

	// ****************************************
	// Handshake steps
	// ****************************************
	sequence seq_pend;
		req && !ack;
	endsequence
	sequence seq_stat_rd;
		ack && !wr && addr == CE_STATUS;
	endsequence
	sequence seq_w0_done;
		ack && !wr && addr == CE_W0SUM;
	endsequence

	// ****************************************
	// Properties
	// ****************************************
	AST_ACK_NEXT: assert property (seq_pend |=> ack)
		else $error("ack missing after request");
	AST_REQ_HOLD: assert property (seq_pend |=> $stable(addr) && $stable(wr) && $stable(wdata))
		else $error("request changed before ack");
	AST_ACK_PULSE: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property (ack |-> $past(req))
		else $error("ack without request");
	AST_XFER_SPACED: assert property (xfer |=> !xfer [*8])
		else $error("pass ended too soon");
	// Results must be pulled while still fresh
	AST_XFER_FETCH: assert property (xfer |-> ##[1:8] (req && !wr && addr == CE_W0SUM))
		else $error("no result fetch after transfer");
	AST_FETCH_PAIR: assert property (seq_w0_done |=> req && !wr && addr == CE_VAR0SUM)
		else $error("second sum not fetched");
	AST_STATUS_ZERO: assert property (seq_stat_rd |-> rdata[31:4] == 28'h0 && !rdata[2])
		else $error("unused status bits set");
	AST_SAG_WARN: assert property (seq_stat_rd ##0 rdata[1:0] == 2'b00 |-> !sag_warn)
		else $error("warning without sag");
	AST_UNMAPPED: assert property (ack && !wr && addr == 8'h30 |-> rdata == 32'h0)
		else $error("unmapped word not zero");
endmodule : mepsag_checker

// *** tb/testbench.sv ***
// Bench joining processor end and engine end over the word link
`timescale 1ns/100ps
module testbench
	import mepsag_pkg::*;
;
	// ****************************************
	// Signals and tables
	// ****************************************
	typedef struct {
		logic [31:0] exp;
		logic [31:0] mask;
		logic err;
	} mepsag_note_s;
	localparam logic [3:0] ADC_SLOT [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'hA};
	localparam logic [31:0] PT_CFG [4] = '{32'h0030_0220, 32'h0030_0222, 32'h0030_0221,
		32'h0030_0220};
	localparam logic [31:0] PT_RATE [4] = '{32'h7FFF_FFFF, 32'h0000_0200, 32'h0008_0000,
		32'h0000_0000};
	localparam logic [1:0] PT_SAG [4] = '{2'h1, 2'h2, 2'h0, 2'h0};
	localparam int PT_NP [4] = '{6, 3, 3, 0};
	logic I_MCLK, I_RESETN, psel, penable, pwrite, pready, pslverr, rd_chk;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, adc_data, va, vb, cur;
	logic adc_valid, real_pulse, reac_pulse, rp_q, qp_q;
	logic [3:0] adc_index;
	int adc_cnt, cyc, n_real, n_reac, err_total, compares;
	mepsag_note_s notes[$];
	mepsag_note_s note;
	mepsag_if bus_if();

	mepsag_host mepsag_host_inst (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .bus(bus_if));
	mepsag_engine mepsag_engine_inst (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN),
		.I_ADC_VALID(adc_valid), .I_ADC_INDEX(adc_index), .I_ADC_DATA(adc_data),
		.bus(bus_if), .O_REAL_PULSE(real_pulse), .O_REACTIVE_PULSE(reac_pulse));
	mepsag_checker mepsag_checker_inst (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN),
		.req(bus_if.req), .wr(bus_if.wr), .addr(bus_if.addr), .wdata(bus_if.wdata),
		.rdata(bus_if.rdata), .ack(bus_if.ack), .xfer(bus_if.xfer),
		.sag_warn(bus_if.sag_warn));

	initial begin
		I_MCLK = 1'b0;
		forever #50 I_MCLK = ~I_MCLK;
	end

	// Converter walks all six slots; currents share one value
	always @(posedge I_MCLK) begin
		cyc <= cyc + 1;
		adc_cnt <= (adc_cnt + 1) % 48;
		adc_valid <= (adc_cnt % 8 == 0);
		adc_index <= ADC_SLOT[adc_cnt / 8];
		adc_data <= (adc_cnt >= 40) ? va : (adc_cnt >= 32) ? vb : cur;
		rp_q <= real_pulse;
		qp_q <= reac_pulse;
		if (real_pulse === 1'b1 && rp_q === 1'b0) n_real++;
		if (reac_pulse === 1'b1 && qp_q === 1'b0) n_reac++;
	end

	// ****************************************
	// Checking and bus tasks
	// ****************************************
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] x, input logic [31:0] m);
		compares++;
		if ((got & m) !== (x & m)) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, x);
		end
	endtask : cmp_word

	task automatic cmp_cnt(input int got, input int lo, input int hi);
		compares++;
		if (got < lo || got > hi) begin
			err_total++;
			$display("[ERR] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
		end
	endtask : cmp_cnt

	always @(posedge I_MCLK) begin
		if (psel && penable && pready === 1'b1 && rd_chk) begin
			note = notes.pop_front();
			cmp_word(prdata, note.exp, note.mask);
			cmp_word({31'h0, pslverr}, {31'h0, note.err}, 32'h1);
		end
	end

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c,
			output logic [31:0] q, output logic e);
		@(posedge I_MCLK);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		rd_chk <= c;
		@(posedge I_MCLK);
		penable <= 1'b1;
		do @(posedge I_MCLK); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		rd_chk <= 1'b0;
	endtask : apb

	task automatic apb_chk(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m,
			input logic err);
		logic [31:0] q;
		logic e;
		notes.push_back('{x, m, err});
		apb(1'b0, a, 32'h0, 1'b1, q, e);
	endtask : apb_chk

	// Link busy with an automatic fetch refuses the command, so retry
	task automatic ce_cmd(input logic [7:0] a, input logic w, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		if (w) apb(1'b1, APB_WDATA, d, 1'b0, q, e);
		do apb(1'b1, APB_CMD, {1'b1, 22'h0, w, a}, 1'b0, q, e); while (e === 1'b1);
		do apb(1'b0, APB_STATUS, 32'h0, 1'b0, q, e); while (q[0] !== 1'b0);
	endtask : ce_cmd

	task automatic ce_chk(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
		ce_cmd(a, 1'b0, 32'h0);
		apb_chk(APB_RDATA, x, m, 1'b0);
	endtask : ce_chk

	task automatic wait_xfer(output int t);
		do @(posedge I_MCLK); while (bus_if.xfer !== 1'b1);
		t = cyc;
	endtask : wait_xfer

	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done

	initial begin
		repeat (98000) @(posedge I_MCLK);
		err_total++;
		$display("[ERR] %0t watchdog expired", $time);
		test_done();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [31:0] s0;
		int t0;
		int t1;
		{I_RESETN, psel, penable, pwrite, rd_chk, adc_valid, rp_q, qp_q} = 8'h00;
		{paddr, pwdata, adc_index, adc_data, vb} = 'h0;
		{adc_cnt, cyc, n_real, n_reac, err_total, compares} = '0;
		va = 32'h4000_0000;
		void'($urandom(77270));
		cur = $urandom_range(32'h3FFF_0000, 32'h0100_0000);
		repeat (5) @(posedge I_MCLK);
		I_RESETN <= 1'b1;
		ce_chk(CE_CFG, CFG_RESET, '1);
		ce_chk(CE_RATE, RATE_RESET, '1);
		for (int g = 0; g < 3; g++) ce_chk(CE_GAIN0 + 8'(g), GAIN_UNITY, '1);
		ce_cmd(CE_STATUS, 1'b1, '1);
		ce_chk(CE_STATUS, 32'h0, '1);
		ce_chk(8'h30, 32'h0, '1);
		apb_chk(8'h40, 32'h0, '1, 1'b1);
		s0 = $urandom;
		ce_cmd(CE_PULSEW, 1'b1, s0);
		ce_chk(CE_PULSEW, s0, '1);
		ce_cmd(CE_ENV, 1'b1, 32'h0002_0001);
		wait_xfer(t0);
		wait_xfer(t1);
		cmp_cnt(t1 - t0, 2 * SAMPLE_CYC, 2 * SAMPLE_CYC);
		// Equal currents make the split formula cancel; zero VB makes two elements match one
		ce_cmd(CE_CFG, 1'b1, CFG_RESET & ~32'h0000_0020);
		// Unity gains: each pass sum outside the split formula is twice the upper half of the current
		s0 = {15'h0, cur[31:16], 1'b0};
		for (int k = 0; k < 3; k++) begin
			ce_cmd(CE_ENV, 1'b1, 32'h0001_0001 | (32'(k) << ENV_EQU));
			wait_xfer(t0);
			wait_xfer(t1);
			repeat (12) @(posedge I_MCLK);
			apb_chk(APB_W0SUM, (k == 1) ? 32'h0 : s0, '1, 1'b0);
		end
		ce_chk(CE_PULSEW, s0, '1);
		ce_cmd(CE_PULSEW, 1'b1, ~s0);
		ce_chk(CE_PULSEW, s0, '1);
		ce_cmd(CE_SAGTHR, 1'b1, 32'h0000_2000);
		for (int k = 0; k < 4; k++) begin
			ce_cmd(CE_CFG, 1'b1, PT_CFG[k]);
			ce_cmd(CE_RATE, 1'b1, PT_RATE[k]);
			ce_cmd(CE_PULSEW, 1'b1, 32'h7FFF_FFFF);
			ce_cmd(CE_PULSER, 1'b1, 32'h8000_0001);
			va <= PT_SAG[k][0] ? 32'h0000_1000 : 32'h4000_0000;
			vb <= PT_SAG[k][1] ? 32'h0000_1000 : 32'h4000_0000;
			repeat (SAMPLE_CYC) @(posedge I_MCLK);
			n_real = 0;
			n_reac = 0;
			repeat (2 * SAMPLE_CYC) @(posedge I_MCLK);
			cmp_cnt(n_real, PT_NP[k] - 1, PT_NP[k] + 1);
			cmp_cnt(n_reac, PT_NP[k] - 1, PT_NP[k] + 1);
			ce_chk(CE_STATUS, {28'h0, 1'b1, 1'b0, PT_SAG[k]}, '1);
			apb_chk(APB_STATUS, {29'h0, |PT_SAG[k], 2'h0}, 32'h4, 1'b0);
		end
		// Paired inputs fold onto the first slot of their pair (IA or IB), leaving the spare slots untouched
		ce_cmd(CE_ENV, 1'b1, 32'h0000_0700);
		ce_cmd(8'(ADC_IA2), 1'b1, 32'h0);
		ce_cmd(8'(ADC_IB2), 1'b1, 32'h0);
		repeat (96) @(posedge I_MCLK);
		ce_chk(8'(ADC_IA2), 32'h0, '1);
		ce_chk(8'(ADC_IB2), 32'h0, '1);
		ce_chk(8'(ADC_IA), cur, '1);
		ce_chk(CE_ADC_LAST, va, '1);
		test_done();
	end
endmodule : testbench
